/* sim/sfpi_host.sv */
`timescale 1ns/1ns
`default_nettype none
module sfpi_host (
  output var  sfpi_pkg::sfpi_pin_in_t  pin_in,
  input  wire sfpi_pkg::sfpi_pin_out_t pin_out
);
  logic       cs_n;
  logic       sclk = 1'b0;
  logic       wp_n = 1'b1;
  logic       hold_n = 1'b1;
  logic       flt = 1'b0;
  logic       paused = 1'b0;
  logic [3:0] hen = 4'h0;
  logic [3:0] drv = 4'h0;
  logic [3:0] lv;

  // Released lines zero and one show a changing pattern
  always #50 flt = ~flt;

  // Wire levels: device drive, host drive, else wp_n and hold_n levels on lines two and three
  always_comb begin
    lv = {hold_n, wp_n, ~flt, flt};
    pin_in.cs_n = cs_n;
    pin_in.sclk = sclk;
    for (int i = 0; i < 4; i++) begin
      pin_in.io[i] = pin_out.io_oe[i] ? pin_out.io_out[i] : (hen[i] ? drv[i] : lv[i]);
    end
  end

  // One frame, 125 ns clock; one spare clock covers the output lag
  task automatic xfer(input logic [7:0] mo, input int ln, input bit w, input bit m3,
                      input int pz, input bit ab, output logic [7:0] mi);
    logic [7:0] sh;
    sh = mo;
    mi = 8'h00;
    sclk = m3;
    #63;
    cs_n = 1'b0;
    #63;
    for (int b = 0; b <= 8 / ln; b++) begin
      sclk = 1'b0;
      hen = (w || ln == 1) ? 4'((1 << ln) - 1) : 4'h0;
      drv = 4'(sh[7:4] >> (4 - ln));
      sh = sh << ln;
      if (b == pz) begin
        // Clock settles low first, so its falling edge still shifts out
        #20;
        hold_n = 1'b0;
        drv = ~drv;
        #60;
        paused = 1'b1;
        repeat (4) #63 sclk = ~sclk;
        paused = 1'b0;
        if (ab) begin
          cs_n = 1'b1;
          hold_n = 1'b1;
          hen = 4'h0;
          #300;
          return;
        end
        drv = ~drv;
        hold_n = 1'b1;
        #60;
      end
      #62;
      sclk = 1'b1;
      mi = (mi << ln) | 8'(ln == 1 ? 4'(pin_in.io[1]) : pin_in.io & 4'((1 << ln) - 1));
      #63;
    end
    if (!m3) sclk = 1'b0;
    #63;
    cs_n = 1'b1;
    hen = 4'h0;
    #300;
  endtask
endmodule
`default_nettype wire

/* sim/sfpi_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module sfpi_checker (
  input wire logic                    core_clk,
  input wire logic                    resetn,
  input wire sfpi_pkg::sfpi_pin_in_t  pin_in,
  input wire sfpi_pkg::sfpi_pin_out_t pin_out,
  input wire logic                    internal_busy,
  input wire logic                    rx_byte_pulse,
  input wire logic                    standby,
  input wire logic                    status_write_block,
  input wire logic                    array_guard_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Pin, standby and guard behaviour against select, clock, busy, guard and pause inputs
  a_deselect_release: assert property (pin_in.cs_n [*5] |-> pin_out.io_oe == 4'h0)
    else $error("outputs driven while deselected");
  a_busy_standby: assert property (internal_busy |-> !standby)
    else $error("standby while busy");
  a_idle_standby: assert property ((pin_in.cs_n && !internal_busy) [*4] |-> standby)
    else $error("no standby while idle");
  a_lane_pairs: assert property (pin_out.io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable set");
  a_out_after_fall: assert property (
    !pin_in.cs_n && !$past(pin_in.cs_n, 4) && $changed(pin_out.io_out)
    && pin_out.io_oe != 4'h0 && $past(pin_out.io_oe) != 4'h0
    |-> !$past(pin_in.sclk) && !$past(pin_in.sclk, 3))
    else $error("output changed away from falling edge");
  a_rx_after_rise: assert property (
    rx_byte_pulse |-> $past(pin_in.sclk) && $past(pin_in.sclk, 3))
    else $error("byte completed away from rising edge");
  a_guard_pin_high: assert property (pin_in.io[2] [*3] |-> !status_write_block)
    else $error("writes blocked with guard pin high");
  a_guard_pair: assert property (status_write_block == array_guard_active)
    else $error("array guard differs from write block");
  a_pause_quiet: assert property (
    (!pin_in.cs_n && !pin_in.io[3] && !pin_in.sclk && pin_out.io_oe != 4'hf) [*8]
    |-> pin_out.io_oe == 4'h0)
    else $error("outputs driven while paused");

  // Main scenarios reached
  c_rx_byte: cover property (rx_byte_pulse);
  c_quad_out: cover property (pin_out.io_oe == 4'hf);
  c_guarded: cover property (status_write_block);
endmodule

bind sfpi_top sfpi_checker u_chk (
  .core_clk(core_clk), .resetn(resetn), .pin_in(pin_in), .pin_out(pin_out),
  .internal_busy(internal_busy), .rx_byte_pulse(rx_byte_pulse), .standby(standby),
  .status_write_block(status_write_block), .array_guard_active(array_guard_active)
);
`default_nettype wire

/* sim/test_serial_flash_pin_interface.sv */
`timescale 1ns/1ns
`default_nettype none
module test_serial_flash_pin_interface;
  localparam logic [7:0] A_CFG = sfpi_pkg::SFPI_OFF_CFG;
  localparam logic [7:0] A_GD  = sfpi_pkg::SFPI_OFF_GUARD;
  localparam logic [7:0] A_TX  = sfpi_pkg::SFPI_OFF_TXDATA;
  localparam logic [7:0] A_RX  = sfpi_pkg::SFPI_OFF_RXDATA;
  localparam logic [7:0] A_ST  = sfpi_pkg::SFPI_OFF_STATUS;
  logic                    core_clk = 1'b0;
  logic                    resetn = 1'b0;
  sfpi_pkg::sfpi_pin_in_t  pin_in;
  sfpi_pkg::sfpi_pin_out_t pin_out;
  logic                    internal_busy = 1'b0;
  logic [7:0]              reg_addr = 8'h00;
  logic [31:0]             reg_wdata = 32'h0000_0000;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic [31:0]             reg_rdata;
  logic                    rx_byte_pulse;
  logic                    standby;
  logic                    status_write_block;
  logic                    array_guard_active;
  logic                    rd_seen = 1'b0;
  logic [31:0]             exp_q[$];
  logic [31:0]             seed = 32'h0000_bc00;
  logic [8:0]              gv[3] = '{9'h001, 9'h005, 9'h003};
  logic [7:0]              tx;
  logic [7:0]              mo;
  logic [7:0]              mi;
  int                      error_cnt = 0;
  int                      comparisons = 0;
  int                      cyc = 0;
  int                      pulses = 0;

  always #5 core_clk = ~core_clk;

  sfpi_top dut (
    .core_clk(core_clk), .resetn(resetn), .pin_in(pin_in), .pin_out(pin_out),
    .internal_busy(internal_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte_pulse(rx_byte_pulse),
    .standby(standby), .status_write_block(status_write_block),
    .array_guard_active(array_guard_active)
  );
  sfpi_host host (.pin_in(pin_in), .pin_out(pin_out));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One register access; a read notes its expected data
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    if (w) reg_wr <= 1'b1;
    else begin
      reg_rd <= 1'b1;
      exp_q.push_back(d);
    end
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic final_report();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read data compared in the one cycle it stands
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front());
  end

  // Completed bytes counted for the closing check
  always @(posedge core_clk) begin
    if (rx_byte_pulse === 1'b1) pulses <= pulses + 1;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    host.cs_n = 1'b0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    bus(0, A_CFG, 32'h0000_0000);
    bus(0, A_GD, 32'h0000_0000);
    bus(0, 8'h14, 32'h0000_0000);
    bus(0, A_ST, 32'h0000_0000);
    host.xfer(8'ha5, 1, 0, 0, -1, 0, mi);
    bus(0, A_ST, 32'h0000_0002);
    internal_busy <= 1'b1;
    bus(0, A_ST, 32'h0000_0000);
    internal_busy <= 1'b0;
    // Single lane in both clock modes
    for (int m = 0; m < 2; m++) begin
      tx = 8'(rnd());
      mo = 8'(rnd());
      bus(1, A_TX, 32'(tx));
      bus(1, A_CFG, 32'h0000_0004);
      host.xfer(mo, 1, 0, m[0], -1, 0, mi);
      chk(32'(mi), 32'(tx));
      bus(0, A_RX, 32'(mo));
      bus(0, A_ST, 32'h0000_0006);
    end
    bus(1, A_CFG, 32'h0000_0006);
    host.xfer(mo, 1, 0, 0, -1, 0, mi);
    bus(0, A_RX, 32'(mo));
    bus(0, A_ST, 32'h0000_0086);
    bus(1, A_ST, 32'h0000_0080);
    // Dual then quad, out and in
    bus(1, A_GD, 32'h0000_0004);
    for (int ln = 2; ln <= 4; ln += 2) begin
      tx = 8'(rnd());
      mo = 8'(rnd()) & 8'h77;
      bus(1, A_TX, 32'(tx));
      bus(1, A_CFG, 32'(ln / 2 + 4));
      host.xfer(8'h00, ln, 0, 0, -1, 0, mi);
      chk(32'(mi), 32'(tx));
      bus(1, A_CFG, 32'(ln / 2));
      host.xfer(mo, ln, 1, 0, -1, 0, mi);
      bus(0, A_RX, 32'(mo));
    end
    // Guard pin against guard bits
    host.wp_n = 1'b0;
    foreach (gv[i]) begin
      bus(1, A_GD, 32'(gv[i]));
      repeat (4) @(posedge core_clk);
      chk(32'({status_write_block, array_guard_active}), i == 0 ? 32'h3 : 32'h0);
      bus(0, A_ST, i == 0 ? 32'h0000_0066 : 32'h0000_0006);
    end
    host.wp_n = 1'b1;
    bus(1, A_GD, 32'h0000_0000);
    // Pause in mid-byte, then pause ended by deselect
    tx = 8'(rnd());
    mo = 8'(rnd());
    bus(1, A_TX, 32'(tx));
    bus(1, A_CFG, 32'h0000_0004);
    fork
      host.xfer(mo, 1, 0, 0, 3, 0, mi);
    join_none
    wait (host.paused);
    bus(0, A_ST, 32'h0000_000d);
    wait fork;
    chk(32'(mi), 32'(tx));
    bus(0, A_RX, 32'(mo));
    internal_busy <= 1'b1;
    host.xfer(~mo, 1, 0, 0, 2, 1, mi);
    bus(0, A_ST, 32'h0000_0004);
    internal_busy <= 1'b0;
    host.xfer(mo, 1, 0, 0, -1, 0, mi);
    bus(0, A_RX, 32'(mo));
    chk(32'(pulses), 32'd9);
    final_report();
  end
endmodule
`default_nettype wire

/* verilog/sfpi_pkg.sv */
`default_nettype none
package sfpi_pkg;
  // Register byte offsets
  localparam logic [7:0] SFPI_OFF_CFG    = 8'h00;
  localparam logic [7:0] SFPI_OFF_GUARD  = 8'h04;
  localparam logic [7:0] SFPI_OFF_TXDATA = 8'h08;
  localparam logic [7:0] SFPI_OFF_RXDATA = 8'h0C;
  localparam logic [7:0] SFPI_OFF_STATUS = 8'h10;

  // Configuration fields
  localparam int unsigned SFPI_CFG_LANE_LSB = 0;
  localparam int unsigned SFPI_CFG_OUT_BIT  = 2;

  // Status fields
  localparam int unsigned SFPI_ST_SEL_BIT     = 0;
  localparam int unsigned SFPI_ST_STBY_BIT    = 1;
  localparam int unsigned SFPI_ST_ARMED_BIT   = 2;
  localparam int unsigned SFPI_ST_PAUSE_BIT   = 3;
  localparam int unsigned SFPI_ST_RXV_BIT     = 4;
  localparam int unsigned SFPI_ST_SRBLK_BIT   = 5;
  localparam int unsigned SFPI_ST_HWPROT_BIT  = 6;
  localparam int unsigned SFPI_ST_QREFUSE_BIT = 7;

  // Reset values
  localparam logic [2:0]  SFPI_CFG_RST   = 3'h0;
  localparam logic [8:0]  SFPI_GUARD_RST = 9'h000;
  localparam logic [7:0]  SFPI_TX_RST    = 8'h00;
  localparam logic [31:0] SFPI_RD_RST    = 32'h0000_0000;

  // Lane usage of the current instruction
  typedef enum logic [1:0] {
    SFPI_LANE_ONE  = 2'b00,
    SFPI_LANE_TWO  = 2'b01,
    SFPI_LANE_FOUR = 2'b10
  } sfpi_lane_t;

  // Link state
  typedef enum logic [1:0] {
    SFPI_LS_UNARMED = 2'b00,
    SFPI_LS_IDLE    = 2'b01,
    SFPI_LS_ACTIVE  = 2'b10,
    SFPI_LS_PAUSED  = 2'b11
  } sfpi_link_t;

  // Pin groups
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } sfpi_pin_in_t;

  typedef struct packed {
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } sfpi_pin_out_t;

  // Status guard bits, GUARD register layout from bit 8 downward
  typedef struct packed {
    logic [2:0] block_guard;
    logic       protect_invert;
    logic       small_unit_granularity;
    logic       top_bottom_select;
    logic       four_lane_enable;
    logic       status_guard_upper;
    logic       status_guard_lower;
  } sfpi_guard_t;
endpackage
`default_nettype wire

/* verilog/sfpi_top.sv */
// Behaviour
// RULE_01: Deselected: ignore inputs, release all outputs
// RULE_02: Deselected and idle means standby; select activates
// RULE_03: First select falling edge arms the interface
// RULE_04: Capture incoming bits on clock rising edges
// RULE_05: Change output data after clock falling edges
// RULE_06: Dual/quad: lines zero, one bidirectional
// RULE_07: Guarded state blocks status register writes
// RULE_08: Guarded state keeps chosen array regions protected
// RULE_09: Four-lane enable turns guard pin into data
// RULE_10: Quad: line two inputs rising, outputs falling
// RULE_11: Pause pin is data line three in quad
// RULE_12: Enter pause only while clock low
// RULE_13: Leave pause only while clock low
// RULE_14: Pause never halts internal write operations
// RULE_15: Host keeps select low throughout pause
// RULE_16: Paused: outputs released, clock and input ignored
// RULE_17: Deselect during pause resets interface state
// RULE_18: Works with clock mode 0 and 3
// RULE_19: Quad only while four-lane enable set
// RULE_20: Single lane: line zero in, one out
`timescale 1ns/1ns
`default_nettype none
module sfpi_top (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire sfpi_pkg::sfpi_pin_in_t pin_in,
  output var  sfpi_pkg::sfpi_pin_out_t pin_out,
  input  wire logic                   internal_busy,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  output logic                        rx_byte_pulse,
  output logic                        standby,
  output logic                        status_write_block,
  output logic                        array_guard_active
);

  // Bits per clock edge for a lane mode
  function automatic logic [3:0] lane_width(input sfpi_pkg::sfpi_lane_t m);
    case (m)
      sfpi_pkg::SFPI_LANE_TWO:  lane_width = 4'd2;
      sfpi_pkg::SFPI_LANE_FOUR: lane_width = 4'd4;
      default:                  lane_width = 4'd1;
    endcase
  endfunction

  // Output enable pattern for a lane mode
  function automatic logic [3:0] lane_oe(input sfpi_pkg::sfpi_lane_t m);
    case (m)
      sfpi_pkg::SFPI_LANE_TWO:  lane_oe = 4'b0011;
      sfpi_pkg::SFPI_LANE_FOUR: lane_oe = 4'b1111;
      default:                  lane_oe = 4'b0010;
    endcase
  endfunction

  // Pin synchronisers, one two-stage chain per pin
  logic [5:0] pin_raw;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] prev_q;
  assign pin_raw = {pin_in.cs_n, pin_in.sclk, pin_in.io};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi]  <= sync2_q[gi];
        end
      end
    end
  endgenerate

  // Synchronised levels and edges
  logic       cs_n_s;
  logic       sclk_s;
  logic [3:0] io_s;
  logic       cs_fall;
  logic       sclk_rise;
  logic       sclk_fall;
  assign cs_n_s    = sync2_q[5];
  assign sclk_s    = sync2_q[4];
  assign io_s      = sync2_q[3:0];
  assign cs_fall   = prev_q[5] & ~cs_n_s;
  assign sclk_rise = ~prev_q[4] & sclk_s;
  assign sclk_fall = prev_q[4] & ~sclk_s;

  // Software registers
  logic [2:0]            cfg_q;
  logic [2:0]            cfg_d;
  sfpi_pkg::sfpi_guard_t guard_q;
  sfpi_pkg::sfpi_guard_t guard_d;
  logic [7:0]            txdata_q;
  logic [7:0]            txdata_d;
  logic [31:0]           rdata_d;
  logic                  rxv_q;
  logic                  rxv_d;
  logic                  qrefuse_q;
  logic                  qrefuse_d;

  // Link state
  sfpi_pkg::sfpi_link_t state_q;
  sfpi_pkg::sfpi_link_t state_d;
  logic [7:0]           rxsh_q;
  logic [7:0]           rxsh_d;
  logic [7:0]           rxbyte_q;
  logic [7:0]           rxbyte_d;
  logic [3:0]           rxcnt_q;
  logic [3:0]           rxcnt_d;
  logic [7:0]           txsh_q;
  logic [7:0]           txsh_d;
  logic [3:0]           txcnt_q;
  logic [3:0]           txcnt_d;
  logic                 seen_rise_q;
  logic                 seen_rise_d;
  logic                 drive_q;
  logic                 drive_d;
  logic [3:0]           dout_q;
  logic [3:0]           dout_d;
  logic [3:0]           oe_q;
  logic [3:0]           oe_d;
  logic                 byte_pulse_q;
  logic                 byte_pulse_d;

  // Guard decode and effective lane mode
  sfpi_pkg::sfpi_lane_t req_mode;
  sfpi_pkg::sfpi_lane_t eff_mode;
  logic                 guard_pin_low;
  logic                 guarded;
  logic                 hold_low;
  logic [3:0]           w;
  logic                 rd_rx;

  assign req_mode = sfpi_pkg::sfpi_lane_t'(cfg_q[sfpi_pkg::SFPI_CFG_LANE_LSB +: 2]);
  // Quad refused unless four-lane enable is set
  assign eff_mode = (req_mode == sfpi_pkg::SFPI_LANE_FOUR && !guard_q.four_lane_enable) ?
                    sfpi_pkg::SFPI_LANE_ONE : req_mode; // RULE_19
  // Guard pin function lost when four lanes are enabled
  assign guard_pin_low = ~guard_q.four_lane_enable & ~io_s[2]; // RULE_09
  assign guarded = guard_pin_low & ~guard_q.status_guard_upper
                   & guard_q.status_guard_lower; // RULE_07
  assign hold_low = (eff_mode != sfpi_pkg::SFPI_LANE_FOUR) & ~io_s[3]; // RULE_11
  assign w = lane_width(eff_mode);
  assign rd_rx = reg_rd && (reg_addr == sfpi_pkg::SFPI_OFF_RXDATA);

  // Link next state: select, pause, shifting
  always_comb begin
    logic [7:0] cur;
    logic [3:0] nsum;
    cur          = txsh_q;
    nsum         = 4'd0;
    state_d      = state_q;
    rxsh_d       = rxsh_q;
    rxbyte_d     = rxbyte_q;
    rxcnt_d      = rxcnt_q;
    txsh_d       = txsh_q;
    txcnt_d      = txcnt_q;
    seen_rise_d  = seen_rise_q;
    drive_d      = drive_q;
    dout_d       = dout_q;
    byte_pulse_d = 1'b0;
    case (state_q)
      sfpi_pkg::SFPI_LS_UNARMED: begin
        if (cs_fall) begin
          state_d = sfpi_pkg::SFPI_LS_ACTIVE; // RULE_03
        end
      end
      sfpi_pkg::SFPI_LS_IDLE: begin
        if (cs_fall) begin
          state_d = sfpi_pkg::SFPI_LS_ACTIVE; // RULE_02
        end
      end
      sfpi_pkg::SFPI_LS_ACTIVE: begin
        if (cs_n_s) begin
          state_d = sfpi_pkg::SFPI_LS_IDLE; // RULE_01
        end else if (hold_low && !sclk_s) begin
          state_d = sfpi_pkg::SFPI_LS_PAUSED; // RULE_12
        end else begin
          // Input capture on rising edges
          if (sclk_rise) begin // RULE_04
            seen_rise_d = 1'b1;
            case (eff_mode)
              sfpi_pkg::SFPI_LANE_TWO:  rxsh_d = {rxsh_q[5:0], io_s[1:0]}; // RULE_06
              sfpi_pkg::SFPI_LANE_FOUR: rxsh_d = {rxsh_q[3:0], io_s}; // RULE_10
              default:                  rxsh_d = {rxsh_q[6:0], io_s[0]}; // RULE_20
            endcase
            nsum = rxcnt_q + w;
            if (nsum >= 4'd8) begin
              rxcnt_d      = 4'd0;
              rxbyte_d     = rxsh_d;
              byte_pulse_d = 1'b1;
            end else begin
              rxcnt_d = nsum;
            end
          end
          // Output shift on falling edges, only after a rising edge
          if (sclk_fall && seen_rise_q && cfg_q[sfpi_pkg::SFPI_CFG_OUT_BIT]) begin // RULE_05 RULE_18
            cur     = (txcnt_q == 4'd0) ? txdata_q : txsh_q;
            drive_d = 1'b1;
            case (eff_mode)
              sfpi_pkg::SFPI_LANE_TWO:  dout_d = {2'b00, cur[7:6]}; // RULE_06
              sfpi_pkg::SFPI_LANE_FOUR: dout_d = cur[7:4]; // RULE_10
              default:                  dout_d = {2'b00, cur[7], 1'b0}; // RULE_20
            endcase
            txsh_d  = cur << w;
            nsum    = txcnt_q + w;
            txcnt_d = (nsum >= 4'd8) ? 4'd0 : nsum;
          end
          if (!cfg_q[sfpi_pkg::SFPI_CFG_OUT_BIT]) begin
            drive_d = 1'b0;
          end
        end
      end
      sfpi_pkg::SFPI_LS_PAUSED: begin
        // Clock and inputs disregarded while paused
        if (cs_n_s) begin
          state_d = sfpi_pkg::SFPI_LS_IDLE; // RULE_17
        end else if (!hold_low && !sclk_s) begin
          state_d = sfpi_pkg::SFPI_LS_ACTIVE; // RULE_13
        end
      end
      default: begin
        state_d = sfpi_pkg::SFPI_LS_UNARMED;
      end
    endcase
    // Frame start or end clears the shift state
    if (state_d == sfpi_pkg::SFPI_LS_IDLE || cs_fall) begin
      rxcnt_d     = 4'd0;
      txcnt_d     = 4'd0;
      seen_rise_d = 1'b0;
      drive_d     = 1'b0;
    end
    // Pins released unless actively driving
    oe_d = (state_d == sfpi_pkg::SFPI_LS_ACTIVE && drive_d) ? lane_oe(eff_mode) : 4'b0000; // RULE_01 RULE_16
  end

  // Link registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= sfpi_pkg::SFPI_LS_UNARMED;
      rxsh_q       <= 8'h00;
      rxbyte_q     <= 8'h00;
      rxcnt_q      <= 4'h0;
      txsh_q       <= 8'h00;
      txcnt_q      <= 4'h0;
      seen_rise_q  <= 1'b0;
      drive_q      <= 1'b0;
      dout_q       <= 4'h0;
      oe_q         <= 4'h0;
      byte_pulse_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      rxsh_q       <= rxsh_d;
      rxbyte_q     <= rxbyte_d;
      rxcnt_q      <= rxcnt_d;
      txsh_q       <= txsh_d;
      txcnt_q      <= txcnt_d;
      seen_rise_q  <= seen_rise_d;
      drive_q      <= drive_d;
      dout_q       <= dout_d;
      oe_q         <= oe_d;
      byte_pulse_q <= byte_pulse_d;
    end
  end

  // Register writes, sticky flags and read mux
  always_comb begin
    cfg_d     = cfg_q;
    guard_d   = guard_q;
    txdata_d  = txdata_q;
    rxv_d     = rxv_q;
    qrefuse_d = qrefuse_q;
    rdata_d   = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        sfpi_pkg::SFPI_OFF_CFG:    cfg_d    = reg_wdata[2:0];
        sfpi_pkg::SFPI_OFF_GUARD:  guard_d  = sfpi_pkg::sfpi_guard_t'(reg_wdata[8:0]);
        sfpi_pkg::SFPI_OFF_TXDATA: txdata_d = reg_wdata[7:0];
        sfpi_pkg::SFPI_OFF_STATUS: begin
          if (reg_wdata[sfpi_pkg::SFPI_ST_QREFUSE_BIT]) begin
            qrefuse_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_rx) begin
      rxv_d = 1'b0;
    end
    // Set wins over clear
    if (byte_pulse_q) begin
      rxv_d = 1'b1;
    end
    if (req_mode == sfpi_pkg::SFPI_LANE_FOUR && !guard_q.four_lane_enable
        && state_q == sfpi_pkg::SFPI_LS_ACTIVE) begin
      qrefuse_d = 1'b1; // RULE_19
    end
    if (reg_rd) begin
      case (reg_addr)
        sfpi_pkg::SFPI_OFF_CFG:    rdata_d = {29'h0, cfg_q};
        sfpi_pkg::SFPI_OFF_GUARD:  rdata_d = {23'h0, guard_q};
        sfpi_pkg::SFPI_OFF_TXDATA: rdata_d = {24'h0, txdata_q};
        sfpi_pkg::SFPI_OFF_RXDATA: rdata_d = {24'h0, rxbyte_q};
        sfpi_pkg::SFPI_OFF_STATUS: begin
          rdata_d[sfpi_pkg::SFPI_ST_SEL_BIT]     = ~cs_n_s & (state_q[1]);
          rdata_d[sfpi_pkg::SFPI_ST_STBY_BIT]    = standby;
          rdata_d[sfpi_pkg::SFPI_ST_ARMED_BIT]   = (state_q != sfpi_pkg::SFPI_LS_UNARMED);
          rdata_d[sfpi_pkg::SFPI_ST_PAUSE_BIT]   = (state_q == sfpi_pkg::SFPI_LS_PAUSED);
          rdata_d[sfpi_pkg::SFPI_ST_RXV_BIT]     = rxv_q;
          rdata_d[sfpi_pkg::SFPI_ST_SRBLK_BIT]   = status_write_block;
          rdata_d[sfpi_pkg::SFPI_ST_HWPROT_BIT]  = array_guard_active;
          rdata_d[sfpi_pkg::SFPI_ST_QREFUSE_BIT] = qrefuse_q;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register bank
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q     <= sfpi_pkg::SFPI_CFG_RST;
      guard_q   <= sfpi_pkg::sfpi_guard_t'(sfpi_pkg::SFPI_GUARD_RST);
      txdata_q  <= sfpi_pkg::SFPI_TX_RST;
      rxv_q     <= 1'b0;
      qrefuse_q <= 1'b0;
      reg_rdata <= sfpi_pkg::SFPI_RD_RST;
    end else begin
      cfg_q     <= cfg_d;
      guard_q   <= guard_d;
      txdata_q  <= txdata_d;
      rxv_q     <= rxv_d;
      qrefuse_q <= qrefuse_d;
      reg_rdata <= rdata_d;
    end
  end

  // Outputs; busy never gated by pause
  assign standby            = cs_n_s & ~internal_busy; // RULE_02 RULE_14
  assign status_write_block = guarded; // RULE_07
  assign array_guard_active = guarded; // RULE_08
  assign rx_byte_pulse      = byte_pulse_q;
  assign pin_out.io_out     = dout_q;
  assign pin_out.io_oe      = oe_q;

endmodule
`default_nettype wire
